// >>> src/irq_status_pkg.sv
// Package: register map, field layout and reset values of the USB interrupt status block
`default_nettype none
package irq_status_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_STATUS_OFF = 8'h00;
  localparam logic [7:0] RX_STATUS_OFF = 8'h04;
  localparam logic [7:0] TX_ENABLE_OFF = 8'h08;
  localparam logic [7:0] RX_ENABLE_OFF = 8'h0C;
  localparam logic [7:0] COMMON_STATUS_OFF = 8'h10;
  localparam logic [7:0] COMMON_ENABLE_OFF = 8'h14;
  localparam logic [7:0] CONTROL_OFF = 8'h18;
  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int EP_BITS = 5;
  localparam int COMMON_BITS = 8;
  localparam int DIRECT_MODE_BIT = 0;
  localparam logic [4:0] TX_VALID_MASK = 5'h1F;
  localparam logic [4:0] RX_VALID_MASK = 5'h1E;
  localparam logic [4:0] TX_ENABLE_RST = 5'h00;
  localparam logic [4:0] RX_ENABLE_RST = 5'h00;
  localparam logic [7:0] COMMON_ENABLE_RST = 8'h06;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Common bus events in register bit order, bit 7 first
  typedef struct packed {
    logic supply_drop_flag;
    logic session_request_flag;
    logic disconnect_flag;
    logic connect_flag;
    logic frame_start;
    logic reset_babble;
    logic resume;
    logic suspend;
  } common_event_t;

  // Endpoint events, one bit per endpoint, bit 0 is the control endpoint in tx and unused in rx
  typedef struct packed {
    logic [4:0] tx;
    logic [4:0] rx;
  } ep_event_t;
endpackage
`default_nettype wire

// >>> src/usb_irq_status.sv
// USB controller interrupt status and enable registers with an AXI4-Lite slave
// Notes on behaviour
// RQ1: Tx status: bit0 control, bits1-4 endpoints
// RQ2: Rx status: bits1-4 endpoints, rest zero
// RQ3: Endpoint status read clears returned bits
// RQ4: Software reads status only in direct mode
// RQ5: Tx enable one bit per source
// RQ6: Rx enable bits1-4, bit0 reads zero
// RQ7: Common status clears on read, unwritable
// RQ8: Bit7 supply drop, A device only
// RQ9: Bit6 session request, A device only
// RQ10: Bit5 disconnect or session end
// RQ11: Bit4 connect, host role only
// RQ12: Bit3 set at every frame start
// RQ13: Bit2 reset in peripheral, babble host
// RQ14: Bit1 resume while suspended
// RQ15: Bit0 suspend, peripheral role only
// RQ16: Common enables; only bits 2,1 reset high
// RQ17: Interrupt while any enabled status set
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`default_nettype none
module usb_irq_status
  import irq_status_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Event pulses from the endpoint and bus logic
  input wire ep_event_t ep_event_in,
  input wire logic vbus_low_in,
  input wire logic session_req_in,
  input wire logic disconnect_in,
  input wire logic session_end_in,
  input wire logic connect_in,
  input wire logic frame_start_in,
  input wire logic bus_reset_in,
  input wire logic babble_in,
  input wire logic resume_in,
  input wire logic suspend_in,
  // Role and state of the controller
  input wire logic host_role_in,
  input wire logic a_device_in,
  input wire logic session_in,
  input wire logic suspended_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt request and mode
  output logic irq_out,
  output logic direct_irq_mode_sel_out
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Release is synchronous so no flop leaves reset on a metastable edge
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0] tx_endpoint_irq_status_r;
  logic [4:0] rx_endpoint_irq_status_r;
  logic [4:0] tx_endpoint_irq_enable_r;
  logic [4:0] rx_endpoint_irq_enable_r;
  logic [7:0] common_bus_event_status_r;
  logic [7:0] common_bus_event_enable_r;
  logic direct_irq_mode_sel_r;

  // ----------------------------------------------------------------
  // Event qualification by role
  // ----------------------------------------------------------------
  common_event_t common_set;

  // Events only count in the role in which they mean something
  assign common_set.supply_drop_flag = vbus_low_in && a_device_in && session_in; // RQ8
  assign common_set.session_request_flag = session_req_in && a_device_in; // RQ9
  assign common_set.disconnect_flag = host_role_in ? disconnect_in : session_end_in; // RQ10
  assign common_set.connect_flag = connect_in && host_role_in; // RQ11
  assign common_set.frame_start = frame_start_in; // RQ12
  assign common_set.reset_babble = host_role_in ? babble_in : bus_reset_in; // RQ13
  assign common_set.resume = resume_in && suspended_in; // RQ14
  assign common_set.suspend = suspend_in && !host_role_in; // RQ15

  logic [4:0] tx_set;
  logic [4:0] rx_set;
  assign tx_set = ep_event_in.tx & TX_VALID_MASK; // RQ1
  assign rx_set = ep_event_in.rx & RX_VALID_MASK; // RQ2

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  // Address and data may arrive in either order; both latch before the write
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;

  wire wr_tx_en = wr_fire && aw_addr_r == TX_ENABLE_OFF;
  wire wr_rx_en = wr_fire && aw_addr_r == RX_ENABLE_OFF;
  wire wr_cm_en = wr_fire && aw_addr_r == COMMON_ENABLE_OFF;
  wire wr_ctrl = wr_fire && aw_addr_r == CONTROL_OFF;
  // Status registers answer a write with OKAY and ignore it
  wire wr_status = aw_addr_r == TX_STATUS_OFF || aw_addr_r == RX_STATUS_OFF
    || aw_addr_r == COMMON_STATUS_OFF;
  wire wr_mapped = wr_status || wr_tx_en || wr_rx_en || wr_cm_en || wr_ctrl;

  // Address and data capture
  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (w_take)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Enable and control registers, low byte lane only
  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_endpoint_irq_enable_r <= TX_ENABLE_RST;
      rx_endpoint_irq_enable_r <= RX_ENABLE_RST;
      common_bus_event_enable_r <= COMMON_ENABLE_RST; // RQ16
      direct_irq_mode_sel_r <= 1'b0;
    end
    else if (w_strb_r[0])
    begin
      if (wr_tx_en)
        tx_endpoint_irq_enable_r <= w_data_r[4:0] & TX_VALID_MASK; // RQ5
      if (wr_rx_en)
        rx_endpoint_irq_enable_r <= w_data_r[4:0] & RX_VALID_MASK; // RQ6
      if (wr_cm_en)
        common_bus_event_enable_r <= w_data_r[7:0]; // RQ16
      if (wr_ctrl)
        direct_irq_mode_sel_r <= w_data_r[DIRECT_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready = !rvalid_r;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_tx_st = rd_take && s_axi_araddr == TX_STATUS_OFF;
  wire rd_rx_st = rd_take && s_axi_araddr == RX_STATUS_OFF;
  wire rd_cm_st = rd_take && s_axi_araddr == COMMON_STATUS_OFF;

  // Read data selection; upper bits always zero
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == TX_STATUS_OFF)
      rd_mux[4:0] = tx_endpoint_irq_status_r; // RQ1
    else if (s_axi_araddr == RX_STATUS_OFF)
      rd_mux[4:0] = rx_endpoint_irq_status_r; // RQ2
    else if (s_axi_araddr == TX_ENABLE_OFF)
      rd_mux[4:0] = tx_endpoint_irq_enable_r;
    else if (s_axi_araddr == RX_ENABLE_OFF)
      rd_mux[4:0] = rx_endpoint_irq_enable_r;
    else if (s_axi_araddr == COMMON_STATUS_OFF)
      rd_mux[7:0] = common_bus_event_status_r;
    else if (s_axi_araddr == COMMON_ENABLE_OFF)
      rd_mux[7:0] = common_bus_event_enable_r;
    else if (s_axi_araddr == CONTROL_OFF)
      rd_mux[DIRECT_MODE_BIT] = direct_irq_mode_sel_r;
    else
      rd_hit = 1'b0;
  end

  // Read data is captured when the address is taken
  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------------------------------
  // Status registers: set wins over read-clear
  // ----------------------------------------------------------------
  // Only the bits the read returned are cleared, so a new event is never lost
  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_endpoint_irq_status_r <= 5'h00;
      rx_endpoint_irq_status_r <= 5'h00;
      common_bus_event_status_r <= 8'h00; // RQ7
    end
    else
    begin
      tx_endpoint_irq_status_r <= (rd_tx_st ? 5'h00 : tx_endpoint_irq_status_r) | tx_set; // RQ3
      rx_endpoint_irq_status_r <= (rd_rx_st ? 5'h00 : rx_endpoint_irq_status_r) | rx_set; // RQ3
      common_bus_event_status_r <= (rd_cm_st ? 8'h00 : common_bus_event_status_r) | common_set; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  wire irq_any = |(tx_endpoint_irq_status_r & tx_endpoint_irq_enable_r)
    || |(rx_endpoint_irq_status_r & rx_endpoint_irq_enable_r)
    || |(common_bus_event_status_r & common_bus_event_enable_r);
  assign irq_out = irq_any; // RQ17
  // Software uses this to decide whether direct status reads are allowed
  assign direct_irq_mode_sel_out = direct_irq_mode_sel_r; // RQ4

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence tx_read_s;
    rd_tx_st && !(|tx_set);
  endsequence

  // Returned word carries the flags that stood at the take, upper bits zero
  chk_tx_upper_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ1
    rd_tx_st |=> s_axi_rvalid && s_axi_rdata[31:5] == 27'h0
      && s_axi_rdata[4:0] == $past(tx_endpoint_irq_status_r))
    else $error("tx status read data wrong");
  chk_rx_bit_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ2
    !rx_endpoint_irq_status_r[0])
    else $error("rx status bit 0 set");
  chk_tx_read_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ3
    tx_read_s |=> tx_endpoint_irq_status_r == 5'h00 && rvalid_r)
    else $error("tx status not cleared by read");
  chk_rx_enable_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ6
    !rx_endpoint_irq_enable_r[0])
    else $error("rx enable bit 0 set");
  chk_common_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ7
    rd_cm_st |=> common_bus_event_status_r == $past(common_set))
    else $error("common status not cleared by read");
  chk_event_set: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ12
    frame_start_in |=> common_bus_event_status_r[3])
    else $error("frame start not flagged");
  chk_connect_role: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ11
    connect_in && !host_role_in && !common_bus_event_status_r[4] |=> !common_bus_event_status_r[4])
    else $error("connect flagged outside host role");
  chk_irq_level: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ17
    (common_bus_event_status_r[2] && common_bus_event_enable_r[2]) |-> irq_out)
    else $error("interrupt missing for enabled event");
  chk_enable_write: assert property (@(posedge mclk_in) disable iff (!rst_n_r) // RQ5
    wr_tx_en && w_strb_r[0] |=> tx_endpoint_irq_enable_r == $past(w_data_r[4:0]))
    else $error("tx enable not written");

endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the USB interrupt status block, driven over AXI4-Lite
`default_nettype none
module tb
  import irq_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus signals, all given a value at time zero
  // ----------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  ep_event_t ep_ev = '0;
  logic [9:0] bus_ev = '0; // vbus_low down to suspend, in port order
  logic [3:0] role = '0; // host, a_device, session, suspended
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out, direct_irq_mode_sel_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  int n_errors = 0;
  int total_checks = 0;
  // Event index, role and expected common status; the role column also proves one qualifier of each event but frame start, session end and babble
  localparam logic [15:0] EV_TAB [17] = '{16'h9680, 16'h9200, 16'h8440, 16'h8000, 16'h7820, 16'h7000, 16'h6020,
    16'h5810, 16'h5000, 16'h4008, 16'h3004, 16'h3800, 16'h2804, 16'h1102, 16'h1000, 16'h0001, 16'h0800};

  usb_irq_status dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ep_event_in(ep_ev),
    .vbus_low_in(bus_ev[9]), .session_req_in(bus_ev[8]), .disconnect_in(bus_ev[7]), .session_end_in(bus_ev[6]),
    .connect_in(bus_ev[5]), .frame_start_in(bus_ev[4]), .bus_reset_in(bus_ev[3]), .babble_in(bus_ev[2]),
    .resume_in(bus_ev[1]), .suspend_in(bus_ev[0]), .host_role_in(role[3]), .a_device_in(role[2]),
    .session_in(role[1]), .suspended_in(role[0]), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out),
    .direct_irq_mode_sel_out(direct_irq_mode_sel_out));

  // 100 MHz clock
  initial
  begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ----------------------------------------------------------------
  // Bus tasks; handshakes are judged at the falling edge, where inputs and readies are settled
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_pend, w_pend, ah, wh;
    int n;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    n = 0;
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel is released at its own handshake edge
    while ((aw_pend || w_pend || s_axi_bvalid !== 1'b1) && n < 100)
    begin
      @(negedge mclk_in);
      ah = aw_pend && s_axi_awready === 1'b1;
      wh = w_pend && s_axi_wready === 1'b1;
      r = s_axi_bresp;
      if (!aw_pend && !w_pend && s_axi_bvalid === 1'b1)
        break;
      @(posedge mclk_in);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      aw_pend = aw_pend && !ah;
      w_pend = w_pend && !wh;
      n++;
    end
    @(posedge mclk_in);
    s_axi_bready <= 1'b0;
    if (n >= 100)
    begin
      $display("mismatch at %0t: write not answered", $time);
      n_errors++;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    int n;
    n = 0;
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge mclk_in);
      hit = s_axi_arready === 1'b1;
      @(posedge mclk_in);
      n++;
    end while (!hit && n < 50);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge mclk_in);
      hit = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk_in);
      n++;
    end while (!hit && n < 100);
    s_axi_rready <= 1'b0;
    if (!hit)
    begin
      $display("mismatch at %0t: read not answered", $time);
      n_errors++;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, exp);
  endtask

  // One-cycle event pulse, then settle so the sticky bit can be seen
  task automatic pulse(input ep_event_t e, input logic [9:0] b);
    @(posedge mclk_in);
    ep_ev <= e;
    bus_ev <= b;
    @(posedge mclk_in);
    ep_ev <= '0;
    bus_ev <= '0;
    @(negedge mclk_in);
  endtask

  task automatic complete_run();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    // The internal reset copy needs two edges before the bus answers
    repeat (4) @(posedge mclk_in);
    // Direct mode first: status registers are only read once it is on
    rd_chk(CONTROL_OFF, 32'h0000_0000);
    axi_write(CONTROL_OFF, 32'h0000_0001, rsp);
    check(32'(direct_irq_mode_sel_out), 32'h0000_0001);
    rd_chk(TX_ENABLE_OFF, 32'h0000_0000);
    rd_chk(RX_ENABLE_OFF, 32'h0000_0000);
    rd_chk(COMMON_ENABLE_OFF, 32'h0000_0006);
    rd_chk(COMMON_STATUS_OFF, 32'h0000_0000);
    check(32'(irq_out), 32'h0000_0000);
    // Endpoint flags, enables and clear on read
    axi_write(TX_ENABLE_OFF, 32'hFFFF_FFFF, rsp);
    axi_write(RX_ENABLE_OFF, 32'hFFFF_FFFF, rsp);
    rd_chk(TX_ENABLE_OFF, 32'h0000_001F);
    rd_chk(RX_ENABLE_OFF, 32'h0000_001E);
    pulse(10'h3FF, 10'h000);
    check(32'(irq_out), 32'h0000_0001);
    rd_chk(TX_STATUS_OFF, 32'h0000_001F);
    check(32'(irq_out), 32'h0000_0001);
    rd_chk(RX_STATUS_OFF, 32'h0000_001E);
    check(32'(irq_out), 32'h0000_0000);
    rd_chk(TX_STATUS_OFF, 32'h0000_0000);
    rd_chk(RX_STATUS_OFF, 32'h0000_0000);
    // Masked control endpoint and the reserved receive bit
    axi_write(TX_ENABLE_OFF, 32'h0000_001E, rsp);
    pulse(10'h021, 10'h000);
    check(32'(irq_out), 32'h0000_0000);
    rd_chk(TX_STATUS_OFF, 32'h0000_0001);
    rd_chk(RX_STATUS_OFF, 32'h0000_0000);
    // Status is not writable; unmapped places refuse
    axi_write(COMMON_STATUS_OFF, 32'hFFFF_FFFF, rsp);
    check(32'(rsp), 32'(RESP_OKAY));
    rd_chk(COMMON_STATUS_OFF, 32'h0000_0000);
    axi_write(8'h40, 32'h0000_0001, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    axi_read(8'h40, rdat, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    // Every common event under a qualifying role, and all but frame start, session end and babble under a non-qualifying one
    foreach (EV_TAB[k])
    begin
      role <= EV_TAB[k][11:8];
      pulse('0, 10'h001 << EV_TAB[k][15:12]);
      check(32'(irq_out), 32'(|(EV_TAB[k][7:0] & COMMON_ENABLE_RST)));
      rd_chk(COMMON_STATUS_OFF, 32'(EV_TAB[k][7:0]));
      rd_chk(COMMON_STATUS_OFF, 32'h0000_0000);
    end
    axi_write(COMMON_ENABLE_OFF, 32'h0000_00FF, rsp);
    rd_chk(COMMON_ENABLE_OFF, 32'h0000_00FF);
    pulse('0, 10'h010);
    check(32'(irq_out), 32'h0000_0001);
    rd_chk(COMMON_STATUS_OFF, 32'h0000_0008);
    check(32'(irq_out), 32'h0000_0000);
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    #100us;
    $display("mismatch at %0t: watchdog expired", $time);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
